// ### core/four_channel_sampling_adc_host_port.v
// control sequencer and parallel read port of a four-channel sampling converter
`default_nettype none
`include "adc_host_port_defines.vh"

// Functional notes
// - trigger rising edge holds all channels, starts
// - convert channels one to four in order
// - trigger asynchronous, synchronised, independent of strobes
// - active-low done output shows converter status
// - drive data only while read and select low
// - twelve-bit two's complement result, bit 11 MSB
// - four consecutive reads return channels one to four
// - selected only while select input is low
// - external conversion clock, internal oscillator when tied
// - track mode resumes when done falls
// - done falls only after all results stored
// - sequence takes 78 or 79 clock edges
// - no direct addressing of result registers
module four_channel_sampling_adc_host_port (
    input wire clock,
    input wire rstn,
    input wire clk_en,
    input wire conversion_trigger_n,
    input wire cs_n,
    input wire rd_n,
    input wire clk_pin,
    input wire [`RESULT_W-1:0] core_result,
    output reg [`RESULT_W-1:0] result_bus,
    output reg result_oe,
    output reg done_n,
    output reg hold,
    output reg [`CH_W-1:0] core_channel,
    output reg internal_osc
);

    // ----------------------------------------------------------------
    // state encoding and end counts
    // ----------------------------------------------------------------
    // one-hot sequencer states and sized end counts of the clock source
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_CONV = 3'h2;
    localparam [2:0] ST_READY = 3'h4;
    localparam [`DIV_W-1:0] DIV_LAST = `OSC_DIV_LAST;
    localparam [`IDLE_W-1:0] IDLE_LAST = `EXT_IDLE_LAST;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    // two-stage copy of the reset input
    reg rst_meta_q;
    reg rst_n;

    // reset asserts at once and leaves through two flip-flops
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // trigger synchroniser
    // ----------------------------------------------------------------
    // synchroniser stages and edge detector of the trigger
    reg trig_meta_q;
    reg trig_sync_q;
    reg trig_prev_q;
    wire start;

    // trigger may move at any time; stages reset to its idle high level
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            trig_meta_q <= `TRIG_RST;
            trig_sync_q <= `TRIG_RST;
            trig_prev_q <= `TRIG_RST;
        end else if (clk_en) begin
            trig_meta_q <= conversion_trigger_n;
            trig_sync_q <= trig_meta_q;
            trig_prev_q <= trig_sync_q;
        end
    end

    // a low-to-high trigger seen after synchronising starts a conversion
    assign start = trig_sync_q & ~trig_prev_q;

    // ----------------------------------------------------------------
    // conversion clock source
    // ----------------------------------------------------------------
    // pin history, idle counter and divider
    reg clkp_prev_q;
    reg [`IDLE_W-1:0] idle_cnt_q;
    reg [`DIV_W-1:0] div_cnt_q;
    // conversion clock ticks from either source
    wire ext_rise;
    wire div_tick;
    wire tick;

    // one tick per pin rising edge, or per divider wrap when the pin is tied
    assign ext_rise = clk_pin & ~clkp_prev_q;
    assign div_tick = (div_cnt_q == DIV_LAST);
    assign tick = internal_osc ? div_tick : ext_rise;

    // a pin that shows no edge for the longest clock period counts as tied
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clkp_prev_q <= 1'b0;
            idle_cnt_q <= {`IDLE_W{1'b0}};
            internal_osc <= `OSC_SEL_RST;
        end else if (clk_en) begin
            clkp_prev_q <= clk_pin;
            if (ext_rise) begin
                idle_cnt_q <= {`IDLE_W{1'b0}};
            end else if (idle_cnt_q != IDLE_LAST) begin
                idle_cnt_q <= idle_cnt_q + 1'b1;
            end
            internal_osc <= (idle_cnt_q == IDLE_LAST) & ~ext_rise;
        end
    end

    // free-running divider that stands in for the internal oscillator
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_q <= {`DIV_W{1'b0}};
        end else if (clk_en) begin
            if (div_tick) begin
                div_cnt_q <= {`DIV_W{1'b0}};
            end else begin
                div_cnt_q <= div_cnt_q + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // conversion sequencer
    // ----------------------------------------------------------------
    // sequencer state, tick count and stored results
    reg [2:0] state_q;
    reg [`EDGE_W-1:0] edge_cnt_q;
    reg [`RESULT_W-1:0] res_q [0:`CH_COUNT-1];
    // slot ends and sequence end
    wire [`EDGE_W-1:0] edge_next;
    wire [`CH_W:0] ch_slot;
    wire [`EDGE_W-1:0] ch_end;
    wire ch_done;
    wire conv_end;

    // each channel slot ends after a fixed number of ticks
    assign edge_next = edge_cnt_q + 1'b1;
    assign ch_slot = {1'b0, core_channel} + 3'h1;
    assign ch_end = `CH_EDGES * {{(`EDGE_W-`CH_W-1){1'b0}}, ch_slot};
    assign ch_done = (state_q == ST_CONV) & tick & (edge_next == ch_end);
    assign conv_end = (state_q == ST_CONV) & tick & (edge_next == `CONV_EDGES);

    // edge count starts on the first tick after the trigger, hence 78 or 79
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            edge_cnt_q <= {`EDGE_W{1'b0}};
            core_channel <= {`CH_W{1'b0}};
            hold <= `HOLD_RST;
        end else if (clk_en) begin
            case (state_q)
                ST_IDLE, ST_READY: begin
                    if (start) begin
                        state_q <= ST_CONV;
                        edge_cnt_q <= {`EDGE_W{1'b0}};
                        core_channel <= {`CH_W{1'b0}};
                        hold <= 1'b1;
                    end
                end
                ST_CONV: begin
                    if (tick) begin
                        edge_cnt_q <= edge_next;
                    end
                    if (ch_done && core_channel != `CH_COUNT - 1) begin
                        core_channel <= core_channel + 1'b1;
                    end
                    if (conv_end) begin
                        state_q <= ST_READY;
                        hold <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    hold <= 1'b0;
                end
            endcase
        end
    end

    // one result register per channel, msb flipped to give two's complement
    genvar g;
    generate
        for (g = 0; g < `CH_COUNT; g = g + 1) begin : g_res
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    res_q[g] <= `RESULT_RST;
                end else if (clk_en && ch_done && core_channel == g) begin
                    res_q[g] <= core_result ^ {1'b1, {(`RESULT_W-1){1'b0}}};
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // read sequencing and two-entry buffer
    // ----------------------------------------------------------------
    // read pointer and two-entry buffer storage
    reg [`PTR_W-1:0] src_ptr_q;
    reg [`RESULT_W-1:0] buf_q [0:1];
    reg buf_wr_q;
    reg buf_rd_q;
    reg [1:0] buf_cnt_q;
    reg rd_act_q;
    // strobe decode and buffer handshake
    wire selected;
    wire rd_req;
    wire read_start;
    wire src_valid;
    wire buf_ready;
    wire push;
    wire pop;

    // a read starts on the first cycle both strobes are seen low
    assign selected = ~cs_n;
    assign rd_req = selected & ~rd_n;
    assign read_start = rd_req & ~rd_act_q;
    assign src_valid = (state_q == ST_READY) & (src_ptr_q != `CH_COUNT);
    assign buf_ready = (buf_cnt_q != 2'h2);
    assign push = src_valid & buf_ready;
    assign pop = read_start & (buf_cnt_q != 2'h0);

    // results leave only in channel order through one pointer
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            src_ptr_q <= {`PTR_W{1'b0}};
            buf_wr_q <= 1'b0;
            buf_rd_q <= 1'b0;
            buf_cnt_q <= 2'h0;
            buf_q[0] <= `RESULT_RST;
            buf_q[1] <= `RESULT_RST;
        end else if (clk_en) begin
            if (start && state_q != ST_CONV) begin
                src_ptr_q <= {`PTR_W{1'b0}};
                buf_wr_q <= 1'b0;
                buf_rd_q <= 1'b0;
                buf_cnt_q <= 2'h0;
            end else begin
                if (push) begin
                    buf_q[buf_wr_q] <= res_q[src_ptr_q[`CH_W-1:0]];
                    buf_wr_q <= ~buf_wr_q;
                    src_ptr_q <= src_ptr_q + 1'b1;
                end
                if (pop) begin
                    buf_rd_q <= ~buf_rd_q;
                end
                buf_cnt_q <= buf_cnt_q + {1'b0, push} - {1'b0, pop};
            end
        end
    end

    // ----------------------------------------------------------------
    // host port outputs
    // ----------------------------------------------------------------
    // strobe history and output enable follow the sampled strobes
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_act_q <= 1'b0;
            result_oe <= 1'b0;
        end else if (clk_en) begin
            rd_act_q <= rd_req;
            result_oe <= rd_req;
        end
    end

    // data register loads only when a buffered word is popped
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            result_bus <= `RESULT_RST;
        end else if (clk_en && pop) begin
            result_bus <= buf_q[buf_rd_q];
        end
    end

    // done rises on a read start or a new trigger; completion in the same cycle wins
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            done_n <= `DONE_N_RST;
        end else if (clk_en) begin
            if (conv_end) begin
                done_n <= 1'b0;
            end else if (read_start || (start && state_q != ST_CONV)) begin
                done_n <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ### core/adc_host_port_defines.vh
// constants for the four-channel sampling converter host port
`ifndef ADC_HOST_PORT_DEFINES_VH
`define ADC_HOST_PORT_DEFINES_VH

// ----------------------------------------------------------------
// data layout
// ----------------------------------------------------------------
`define RESULT_W 12
`define RESULT_MSB 11
`define CH_COUNT 4
`define CH_W 2
`define PTR_W 3

// ----------------------------------------------------------------
// conversion sequence, counted in conversion clock rising edges
// ----------------------------------------------------------------
`define EDGE_W 7
`define CONV_EDGES 7'h4E
`define CH_EDGES 7'h13

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define INT_OSC_PERIOD_NS 400
`define OSC_DIV_CYCLES (`INT_OSC_PERIOD_NS / `CLK_PERIOD_NS)
`define DIV_W 4
`define EXT_IDLE_NS 10000
`define EXT_IDLE_CYCLES (`EXT_IDLE_NS / `CLK_PERIOD_NS)
`define IDLE_W 8
`define OSC_DIV_LAST 4'h9
`define EXT_IDLE_LAST 8'hFA

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DONE_N_RST 1'b1
`define HOLD_RST 1'b0
`define OSC_SEL_RST 1'b0
`define RESULT_RST 12'h000
`define TRIG_RST 1'b1

`endif

// ### tb/adc_port_checker.sv
// assertion checker for the converter host port
`default_nettype none
`include "adc_host_port_defines.vh"
module adc_port_checker (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic conversion_trigger_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic clk_pin,
    input wire logic [`RESULT_W-1:0] core_result,
    input wire logic [`RESULT_W-1:0] result_bus,
    input wire logic result_oe,
    input wire logic done_n,
    input wire logic hold,
    input wire logic [`CH_W-1:0] core_channel,
    input wire logic internal_osc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pin_q;
    logic [7:0] ticks_q;
    wire logic pin_edge = clk_pin && !pin_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // ----------------------------------------
    // helper: conversion clock edges seen while holding
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pin_q <= 1'b0;
            ticks_q <= 8'h00;
        end else begin
            pin_q <= clk_pin;
            ticks_q <= hold ? ticks_q + {7'h00, pin_edge} : 8'h00;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    start_hold_a: assert property ($rose(conversion_trigger_n) && !hold |-> ##[1:5] hold)
        else $error("trigger did not start a conversion");
    start_channel_a: assert property ($rose(hold) |-> core_channel == 2'h0 && done_n)
        else $error("conversion did not start at channel one");
    channel_step_a: assert property (hold && $past(hold) && $changed(core_channel)
        |-> core_channel == $past(core_channel) + 2'h1) else $error("channel order broken");
    done_after_all_a: assert property ($fell(done_n) |-> $past(core_channel) == 2'h3)
        else $error("done before last channel");
    track_on_done_a: assert property ($fell(done_n) == $fell(hold))
        else $error("hold release not tied to done");
    // one edge of slack: the edge that raises hold may itself carry a tick
    conv_edges_a: assert property ($fell(hold) && !internal_osc
        |-> (ticks_q + {7'h00, pin_edge}) inside {[8'd78:8'd79]}) else $error("bad edge count");
    oe_window_a: assert property (result_oe == $past(!cs_n && !rd_n))
        else $error("output enable not following strobes");
    done_rise_a: assert property ($rose(done_n) |-> $past(!cs_n && !rd_n) || hold)
        else $error("done cleared without read or start");
    bus_holds_a: assert property (!$past(!cs_n && !rd_n) |-> $stable(result_bus))
        else $error("result changed without read");
endmodule
`default_nettype wire

// ### tb/adc_core_model.sv
// far-side model: analog core results and the conversion clock pin
`default_nettype none
module adc_core_model (
    input wire logic clock,
    input wire logic stop,
    input wire logic [1:0] core_channel,
    output wire logic clk_pin,
    output wire logic [11:0] core_result
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_q = 2'h0;

    // conversion clock at a quarter rate; pin tied low when stopped
    always_ff @(posedge clock) begin
        div_q <= div_q + 2'h1;
    end
    assign clk_pin = div_q[1] & ~stop;
    // offset-binary word, distinct for each channel
    assign core_result = {core_channel, core_channel, 8'h5A};
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the converter host port
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic trig_n = 1'b1;
    logic cs_n = 1'b1;
    logic rd_n = 1'b1;
    logic stop = 1'b0;
    wire logic clk_pin, result_oe, done_n, hold, internal_osc;
    wire logic [11:0] core_result, result_bus;
    wire logic [1:0] core_channel;
    int bad_count = 0;
    int n_compared = 0;

    always #20 clock = ~clock;

    four_channel_sampling_adc_host_port DUT (.clock(clock), .rstn(rstn), .clk_en(1'b1),
        .conversion_trigger_n(trig_n), .cs_n(cs_n), .rd_n(rd_n), .clk_pin(clk_pin),
        .core_result(core_result), .result_bus(result_bus), .result_oe(result_oe),
        .done_n(done_n), .hold(hold), .core_channel(core_channel),
        .internal_osc(internal_osc));
    adc_core_model core (.clock(clock), .stop(stop), .core_channel(core_channel),
        .clk_pin(clk_pin), .core_result(core_result));

    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    function automatic logic [11:0] word(input logic [1:0] ch);
        return {~ch[1], ch[0], ch, 8'h5A};
    endfunction
    task automatic convert;
        int i;
        @(posedge clock);
        trig_n <= 1'b0;
        repeat (2) @(posedge clock);
        trig_n <= 1'b1;
        for (i = 0; i < 9 && hold !== 1'b1; i++) @(negedge clock);
        check(hold, 1'b1);
        for (i = 0; i < 3000 && done_n !== 1'b0; i++) @(negedge clock);
        check(done_n, 1'b0);
        check(hold, 1'b0);
        check(core_channel, 2'h3);
    endtask
    task automatic read_word(input logic [11:0] exp);
        @(posedge clock);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        tick(2);
        check(result_oe, 1'b1);
        check(result_bus, exp);
        check(done_n, 1'b1);
        @(posedge clock);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        tick(2);
        check(result_oe, 1'b0);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        check(done_n, 1'b1);
        check(hold, 1'b0);
        check(internal_osc, 1'b0);
        $display("test reset values done");
    endtask
    task automatic t_half_strobe;
        @(posedge clock);
        cs_n <= 1'b0;
        tick(3);
        check(result_oe, 1'b0);
        @(posedge clock);
        cs_n <= 1'b1;
        rd_n <= 1'b0;
        tick(3);
        check(result_oe, 1'b0);
        @(posedge clock);
        rd_n <= 1'b1;
        tick(2);
        $display("test single strobe done");
    endtask
    task automatic t_four_reads;
        int c;
        convert();
        for (c = 0; c < 4; c++) read_word(word(c[1:0]));
        read_word(word(2'h3));
        $display("test four reads done");
    endtask
    task automatic t_restart;
        convert();
        read_word(word(2'h0));
        read_word(word(2'h1));
        @(posedge clock);
        cs_n <= 1'b0;
        convert();
        @(posedge clock);
        cs_n <= 1'b1;
        read_word(word(2'h0));
        $display("test restart done");
    endtask
    task automatic t_internal;
        @(posedge clock);
        stop <= 1'b1;
        tick(300);
        check(internal_osc, 1'b1);
        convert();
        read_word(word(2'h0));
        $display("test internal clock done");
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        tick(4);
        t_reset();
        t_half_strobe();
        t_four_reads();
        t_restart();
        t_internal();
        tally_and_finish();
    end
    // watchdog well beyond the few thousand cycles the tests need
    initial begin
        #(40 * 20000);
        bad_count++;
        tally_and_finish();
    end
endmodule
bind four_channel_sampling_adc_host_port adc_port_checker chk (.clock(clock), .rstn(rstn),
    .clk_en(clk_en), .conversion_trigger_n(conversion_trigger_n), .cs_n(cs_n), .rd_n(rd_n),
    .clk_pin(clk_pin), .core_result(core_result), .result_bus(result_bus),
    .result_oe(result_oe), .done_n(done_n), .hold(hold), .core_channel(core_channel),
    .internal_osc(internal_osc));
`default_nettype wire
